// ==== wdt_pkg.sv ====
// Package for the 24-bit watchdog: register map, reset values, response modes
package wdt_pkg;
  localparam int          CNT_W          = 24;
  localparam logic [11:0] OFS_RELOAD_U   = 12'hff1;
  localparam logic [11:0] OFS_RELOAD_M   = 12'hff2;
  localparam logic [11:0] OFS_RELOAD_L   = 12'hff3;
  localparam logic [11:0] OFS_CTRL       = 12'hff4;
  localparam logic [11:0] OFS_STATUS     = 12'hff5;
  localparam logic [11:0] OFS_INT_STAT   = 12'hff6;
  localparam logic [11:0] OFS_INT_MASK   = 12'hff7;
  localparam logic [7:0]  RST_RELOAD_U   = 8'h00;
  localparam logic [7:0]  RST_RELOAD_M   = 8'h04;
  localparam logic [7:0]  RST_RELOAD_L   = 8'h00;
  localparam logic [23:0] CNT_ZERO       = 24'h000000;
  localparam logic [23:0] CNT_MAX        = 24'hffffff;
  localparam int          CTRL_EN_BIT    = 0;
  localparam int          STAT_TMO_BIT   = 7;
  localparam int          STAT_STOP_BIT  = 6;
  localparam int          IRQ_TMO_BIT    = 0;
  localparam int          IRQ_SMR_BIT    = 1;
  localparam int          TICK_DIV       = 4;
  localparam logic [1:0]  OPT_SETTLE     = 2'h2;
  typedef enum logic {WDT_RESP_RESET, WDT_RESP_IRQ} wdt_resp_t;
endpackage : wdt_pkg

// ==== wdt_tick.sv ====
// Divider producing the one-cycle count tick
`timescale 1ns/1ns
module wdt_tick (
  input  wire logic core_clk,
  input  wire logic rst_n,
  output logic      tick
);
  import wdt_pkg::*;
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } wdt_tick_t;
  wdt_tick_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 8'(TICK_DIV - 1)) begin
      s_d.cnt = 8'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick = s_q.tick;
endmodule : wdt_tick

// ==== wdt_core.sv ====
// Watchdog timer top: counter, reload bytes, status, interrupt and reset request
`timescale 1ns/1ns
module wdt_core (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        refresh,
  input  wire logic        debug_mode,
  input  wire logic        stop_mode,
  input  wire logic        timeout_response_option,
  output logic             wdt_irq_req,
  output logic             stop_recovery_req,
  output logic             sys_reset_req,
  output logic             irq
);
  import wdt_pkg::*;
  typedef struct packed {
    logic [23:0] cnt;
    logic [23:0] reload;
    logic        en;
    logic        running;
    logic        opt_cap;
    logic [1:0]  opt_wait;
    wdt_resp_t   resp;
    logic        tmo_flag;
    logic        stop_flag;
    logic        irq_req;
    logic        smr;
    logic        rst_req;
    logic [1:0]  int_stat;
    logic [1:0]  int_mask;
    logic [7:0]  rdata;
    logic [1:0]  opt_sync;
    logic [1:0]  stop_sync;
    logic [1:0]  dbg_sync;
  } wdt_state_t;
  wdt_state_t s_q, s_d;
  logic tick;
  logic tmo;
  logic stop_s;
  logic dbg_s;
  wdt_tick u_tick (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (tick)
  );
  assign stop_s = s_q.stop_sync[1];
  assign dbg_s  = s_q.dbg_sync[1];
  // Time-out only while running and counting from one down to zero
  assign tmo = s_q.running && s_q.en && tick && !refresh && !dbg_s
               && (s_q.cnt == 24'h000001);
  always_comb begin
    s_d = s_q;
    s_d.opt_sync  = {s_q.opt_sync[0], timeout_response_option};
    s_d.stop_sync = {s_q.stop_sync[0], stop_mode};
    s_d.dbg_sync  = {s_q.dbg_sync[0], debug_mode};
    s_d.smr = 1'b0;
    s_d.rdata = 8'h00;
    // Option is latched once, after the synchroniser has settled; earlier the
    // second stage still holds its reset value and would always pick reset mode
    if (!s_q.opt_cap) begin
      if (s_q.opt_wait == OPT_SETTLE) begin
        s_d.opt_cap = 1'b1;
        s_d.resp = s_q.opt_sync[1] ? WDT_RESP_IRQ : WDT_RESP_RESET;
      end else begin
        s_d.opt_wait = s_q.opt_wait + 2'h1;
      end
    end
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_RELOAD_U: s_d.reload[23:16] = reg_wdata;
        OFS_RELOAD_M: s_d.reload[15:8] = reg_wdata;
        OFS_RELOAD_L: s_d.reload[7:0] = reg_wdata;
        OFS_CTRL:     s_d.en = reg_wdata[CTRL_EN_BIT];
        OFS_INT_STAT: s_d.int_stat = s_q.int_stat & ~reg_wdata[1:0];
        OFS_INT_MASK: s_d.int_mask = reg_wdata[1:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_RELOAD_U: s_d.rdata = s_q.cnt[23:16];
        OFS_RELOAD_M: s_d.rdata = s_q.cnt[15:8];
        OFS_RELOAD_L: s_d.rdata = s_q.cnt[7:0];
        OFS_CTRL:     s_d.rdata = {7'h00, s_q.en};
        OFS_STATUS: begin
          s_d.rdata = {s_q.tmo_flag, s_q.stop_flag, 6'h00};
          s_d.tmo_flag = 1'b0;
          s_d.stop_flag = 1'b0;
          s_d.irq_req = 1'b0;
        end
        OFS_INT_STAT: s_d.rdata = {6'h00, s_q.int_stat};
        OFS_INT_MASK: s_d.rdata = {6'h00, s_q.int_mask};
        default: s_d.rdata = 8'h00;
      endcase
    end
    if (!s_q.en) begin
      s_d.running = 1'b0;
    end else if (!s_q.running) begin
      s_d.running = 1'b1;
      s_d.cnt = s_q.reload;
    end else if (refresh || dbg_s) begin
      s_d.cnt = s_q.reload;
    end else if (tick) begin
      s_d.cnt = s_q.cnt - 24'h000001;
      if (tmo && s_q.resp == WDT_RESP_IRQ) begin
        s_d.cnt = CNT_MAX;
      end
    end
    // Set wins over the read clear
    if (tmo) begin
      s_d.tmo_flag = 1'b1;
      s_d.int_stat[IRQ_TMO_BIT] = 1'b1;
      if (stop_s) begin
        s_d.stop_flag = 1'b1;
      end
      if (s_q.resp == WDT_RESP_IRQ) begin
        s_d.irq_req = 1'b1;
        if (stop_s) begin
          s_d.smr = 1'b1;
          s_d.int_stat[IRQ_SMR_BIT] = 1'b1;
        end
      end else begin
        s_d.rst_req = 1'b1;
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.reload <= {RST_RELOAD_U, RST_RELOAD_M, RST_RELOAD_L};
      s_q.resp <= WDT_RESP_RESET;
    end else begin
      s_q <= s_d;
    end
  end
  // Request held until status read; controller gates it with its global enable
  assign wdt_irq_req       = s_q.irq_req;
  assign stop_recovery_req = s_q.smr;
  // Reset request is sticky: the system reset itself clears it
  assign sys_reset_req     = s_q.rst_req;
  assign reg_rdata         = s_q.rdata;
  assign irq               = |(s_q.int_stat & s_q.int_mask);

  reload_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.en && !s_q.running)
    |=> (s_q.cnt == $past(s_q.reload) && s_q.running))
    else $error("Enable did not load reload value");
  count_dec_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.running && s_q.en && tick && !refresh && !dbg_s && s_q.cnt > 24'h000001)
    |=> s_q.cnt == $past(s_q.cnt) - 24'h000001)
    else $error("Counter did not decrement on tick");
  refresh_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.running && s_q.en && refresh)
    |=> s_q.cnt == $past(s_q.reload))
    else $error("Refresh did not reload counter");
  debug_notmo_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.running && s_q.en && dbg_s)
    |=> (s_q.cnt == $past(s_q.reload) && !$rose(wdt_irq_req)))
    else $error("Debug mode did not keep the watchdog refreshed");
  reset_resp_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (tmo && s_q.resp == WDT_RESP_RESET)
    |=> sys_reset_req)
    else $error("Reset response missing");
  irq_resp_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (tmo && s_q.resp == WDT_RESP_IRQ)
    |=> (wdt_irq_req && s_q.tmo_flag && s_q.cnt == CNT_MAX))
    else $error("Interrupt time-out response wrong");
  stop_tmo_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (tmo && stop_s && s_q.resp == WDT_RESP_IRQ)
    |=> (stop_recovery_req && s_q.stop_flag) ##1 !stop_recovery_req)
    else $error("Stop time-out handling wrong");
  status_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_STATUS && !tmo)
    |=> (!s_q.tmo_flag && !wdt_irq_req))
    else $error("Status read did not clear flag");
  reload_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == OFS_RELOAD_M)
    |=> s_q.reload[15:8] == $past(reg_wdata))
    else $error("Middle reload byte not written");
  reload_u_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == OFS_RELOAD_U)
    |=> s_q.reload[23:16] == $past(reg_wdata))
    else $error("Upper reload byte not written");
  reload_l_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == OFS_RELOAD_L)
    |=> s_q.reload[7:0] == $past(reg_wdata))
    else $error("Low reload byte not written");
  reload_keep_cnt_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == OFS_RELOAD_L && s_q.running && s_q.en
    && !refresh && !dbg_s && !tick) |=> s_q.cnt == $past(s_q.cnt))
    else $error("Reload write disturbed the running count");
  rd_cnt_u_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_RELOAD_U)
    |=> reg_rdata == $past(s_q.cnt[23:16]))
    else $error("Upper byte read did not return the count");
  rd_cnt_m_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_RELOAD_M)
    |=> reg_rdata == $past(s_q.cnt[15:8]))
    else $error("Middle byte read did not return the count");
  rd_cnt_l_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_RELOAD_L)
    |=> reg_rdata == $past(s_q.cnt[7:0]))
    else $error("Low byte read did not return the count");
  tmo_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (tmo && s_q.resp == WDT_RESP_RESET)
    |=> s_q.cnt == CNT_ZERO)
    else $error("Reset mode time-out did not reach zero");
  tmo_flag_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    tmo
    |=> (s_q.tmo_flag && s_q.int_stat[IRQ_TMO_BIT]))
    else $error("Time-out flag not set");
  stop_both_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (tmo && stop_s)
    |=> (s_q.stop_flag && s_q.tmo_flag))
    else $error("Stop time-out did not set both flags");
  stop_flag_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (tmo && !stop_s && !(reg_rd && reg_addr == OFS_STATUS))
    |=> s_q.stop_flag == $past(s_q.stop_flag))
    else $error("Stop flag changed on a running time-out");
  smr_only_tmo_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !tmo
    |=> !stop_recovery_req)
    else $error("Stop recovery without time-out");
  smr_with_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    stop_recovery_req
    |-> (wdt_irq_req && s_q.int_stat[IRQ_SMR_BIT]))
    else $error("Stop recovery without interrupt request");
  refresh_no_tmo_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.en && refresh)
    |=> !$rose(wdt_irq_req))
    else $error("Time-out raised despite refresh");
  en_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !s_q.en
    |=> !s_q.running)
    else $error("Counter kept running while disabled");
  tick_period_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    tick
    |=> !tick ##1 !tick ##1 !tick ##1 tick)
    else $error("Count tick spacing wrong");
  ctrl_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == OFS_CTRL)
    |=> s_q.en == $past(reg_wdata[CTRL_EN_BIT]))
    else $error("Enable bit not written");
  ctrl_rd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_CTRL)
    |=> reg_rdata == {7'h00, $past(s_q.en)})
    else $error("Control read wrong");
  mask_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == OFS_INT_MASK)
    |=> s_q.int_mask == $past(reg_wdata[1:0]))
    else $error("Interrupt mask not written");
  status_rd_data_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_STATUS)
    |=> reg_rdata == {$past(s_q.tmo_flag), $past(s_q.stop_flag), 6'h00})
    else $error("Status read data wrong");
  stop_flag_clr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_STATUS && !tmo)
    |=> !s_q.stop_flag)
    else $error("Status read did not clear stop flag");
  opt_capture_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!s_q.opt_cap && s_q.opt_wait == OPT_SETTLE)
    |=> (s_q.opt_cap && ((s_q.resp == WDT_RESP_IRQ) == $past(s_q.opt_sync[1]))))
    else $error("Response option not captured");
  opt_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_q.opt_cap
    |=> s_q.resp == $past(s_q.resp))
    else $error("Response option changed after capture");
  irq_no_rst_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.resp == WDT_RESP_IRQ && !sys_reset_req)
    |=> !sys_reset_req)
    else $error("Reset request in interrupt mode");
  rst_no_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.resp == WDT_RESP_RESET && !wdt_irq_req)
    |=> !wdt_irq_req)
    else $error("Interrupt request in reset mode");
  sys_rst_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    sys_reset_req
    |=> sys_reset_req)
    else $error("Reset request dropped");
  irq_req_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wdt_irq_req && !(reg_rd && reg_addr == OFS_STATUS))
    |=> wdt_irq_req)
    else $error("Pending interrupt request dropped");
  int_w1c_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == OFS_INT_STAT && !tmo)
    |=> (s_q.int_stat & $past(reg_wdata[1:0])) == 2'h0)
    else $error("Interrupt status not cleared by write");
  int_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.int_stat[IRQ_TMO_BIT] && !(reg_wr && reg_addr == OFS_INT_STAT))
    |=> s_q.int_stat[IRQ_TMO_BIT])
    else $error("Interrupt status bit not sticky");
  rdata_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !reg_rd
    |=> reg_rdata == 8'h00)
    else $error("Read data outside a read cycle");
endmodule : wdt_core

// ==== wdt_cpu.sv ====
// CPU and interrupt controller stand-in for the watchdog core
`timescale 1ns/1ns
module wdt_cpu (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic kick,
  input  wire logic irq_en,
  input  wire logic wdt_irq_req,
  output logic      refresh,
  output int        served
);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh <= 1'b0;
      served  <= 0;
    end else begin
      // One-cycle refresh instruction, only when commanded
      refresh <= kick;
      // Vector fetched only with global enable; the request waits otherwise
      if (wdt_irq_req && irq_en) served <= served + 1;
    end
  end
endmodule : wdt_cpu

// ==== testbench.sv ====
// Self-checking bench for the watchdog core
`timescale 1ns/1ns
module testbench;
  import wdt_pkg::*;
  logic        core_clk, rst_n, reg_wr, reg_rd, debug_mode, stop_mode, opt, kick, irq_en;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, d;
  logic        refresh, wdt_irq_req, stop_recovery_req, sys_reset_req, irq;
  int          fails, comparisons, served, seed, rl, n;
  wdt_core u_wdt_core (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .refresh, .debug_mode, .stop_mode, .timeout_response_option(opt),
    .wdt_irq_req, .stop_recovery_req, .sys_reset_req, .irq);
  wdt_cpu u_wdt_cpu (.core_clk, .rst_n, .kick, .irq_en, .wdt_irq_req, .refresh, .served);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic rst(input logic o);
    opt   <= o;
    rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : rst
  // Reference: time-out lands some four cycles per count step after enable or refresh
  task automatic wt;
    n = 0;
    while (!(wdt_irq_req | sys_reset_req | stop_recovery_req) && n < 4 * rl + 40) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask : wt
  initial begin
    {reg_wr, reg_rd, debug_mode, stop_mode, kick, irq_en} = '0;
    {reg_addr, reg_wdata} = '0;
    seed = 32'h4564;
    rst(1'b1);
    wr(OFS_CTRL, 8'h01);
    rd(OFS_RELOAD_M);
    chk("reload_mid_rst", 8'h01, 8'(d === 8'h04 || d === 8'h03));
    rd(OFS_RELOAD_U);
    chk("reload_up_rst", RST_RELOAD_U, d);
    wr(OFS_CTRL, 8'h00);
    rl = 4 + ($random(seed) & 63); // Never below four
    wr(OFS_RELOAD_M, 8'(rl >> 8));
    wr(OFS_RELOAD_L, 8'(rl));
    wr(OFS_INT_MASK, 8'h03);
    wr(OFS_CTRL, 8'h01);
    wt;
    chk("tmo_time", 8'h01, 8'(n >= 4 * rl - 4 && n <= 4 * rl + 8));
    chk("irq_req", 8'h01, 8'(wdt_irq_req));
    rd(OFS_RELOAD_U);
    chk("wrap_upper", 8'hff, d);
    rd(OFS_STATUS);
    chk("status_tmo", 8'h80, d);
    chk("irq_req_clr", 8'h00, 8'(wdt_irq_req));
    chk("irq_out", 8'h01, 8'(irq));
    wr(OFS_INT_STAT, 8'h03);
    @(posedge core_clk);
    chk("irq_w1c", 8'h00, 8'(irq));
    repeat (rl + 4) begin
      kick <= 1'b1;
      @(posedge core_clk);
      kick <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    chk("refresh_hold", 8'h00, 8'(wdt_irq_req));
    rd(OFS_RELOAD_L);
    chk("refresh_cnt", 8'h01, 8'(d === 8'(rl) || d === 8'(rl - 1)));
    debug_mode <= 1'b1;
    repeat (4 * rl + 20) @(posedge core_clk);
    chk("debug_hold", 8'h00, 8'(wdt_irq_req));
    debug_mode <= 1'b0;
    stop_mode  <= 1'b1;
    wt;
    chk("stop_recover", 8'h01, 8'(stop_recovery_req));
    repeat (2) @(posedge core_clk);
    chk("served_masked", 8'h00, 8'(served));
    irq_en <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("served", 8'h01, 8'(served > 0));
    rd(OFS_STATUS);
    chk("status_stop", 8'hc0, d);
    rd(OFS_INT_STAT);
    chk("int_stat", 8'h03, d);
    rd(OFS_INT_MASK);
    chk("int_mask", 8'h03, d);
    rd(OFS_CTRL);
    chk("ctrl_en", 8'h01, d);
    rd(12'h0f0);
    chk("unmapped", 8'h00, d);
    stop_mode <= 1'b0;
    rst(1'b0);
    wr(OFS_CTRL, 8'h01);
    rl = int'({RST_RELOAD_U, RST_RELOAD_M, RST_RELOAD_L});
    wt;
    chk("sys_reset", 8'h01, 8'(sys_reset_req));
    chk("no_irq_req", 8'h00, 8'(wdt_irq_req));
    report_and_stop;
  end
  initial begin
    #2000000;
    fails++;
    report_and_stop;
  end
endmodule : testbench
